/* File: shared/phy_regs_pkg.sv */
package phy_regs_pkg;
	// ==========================================================
	// Register byte offsets (printed offsets not all multiples of four: index * 4)
	localparam logic [7:0] IDX_PKT_LEN = 8'h1c;
	localparam logic [7:0] IDX_CABLE = 8'h1e;
	localparam logic [7:0] IDX_RESET = 8'h1f;
	localparam logic [7:0] IDX_MULTI_PURPOSE_LED = 8'h25;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
	localparam logic [9:0] ADDR_PKT_LEN = {IDX_PKT_LEN, 2'b00};
	localparam logic [9:0] ADDR_CABLE = {IDX_CABLE, 2'b00};
	localparam logic [9:0] ADDR_RESET = {IDX_RESET, 2'b00};
	localparam logic [9:0] ADDR_MULTI_PURPOSE_LED = {IDX_MULTI_PURPOSE_LED, 2'b00};
	localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

	// ==========================================================
	// Field positions and reset values
	localparam logic [10:0] PKT_LEN_RESET = 11'h5ee;
	localparam int CABLE_START_BIT = 15;
	localparam int CABLE_DONE_BIT = 1;
	localparam int CABLE_FAIL_BIT = 0;
	localparam logic [12:0] CABLE_RSVD_VAL = 13'h0040;
	localparam int SOFT_RESET_BIT = 15;
	localparam int RESTART_BIT = 14;
	localparam int POL_BIT = 9;
	localparam int SRC_LSB = 3;
	localparam int ROUTE_LSB = 0;
	localparam int IRQ_BITS = 3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_LOST = 2;
	localparam logic [1:0] ROUTE_COL = 2'h0;
	localparam logic [1:0] ROUTE_LED0 = 2'h1;

	// LED source codes
	typedef enum logic [3:0] {
		SRC_LINK = 4'h0, SRC_ACT = 4'h1, SRC_TX = 4'h2, SRC_RX = 4'h3,
		SRC_COL = 4'h4, SRC_SPD100 = 4'h5, SRC_SPD10 = 4'h6, SRC_FDX = 4'h7,
		SRC_LINK_BLINK = 4'h8, SRC_STRETCH = 4'h9, SRC_LINK100FD = 4'ha,
		SRC_LPI = 4'hb, SRC_MII_ERR = 4'hc, SRC_LINK_LOST = 4'hd,
		SRC_PRBS_ERR = 4'he, SRC_RSVD = 4'hf
	} led_src_t;

	// Status bundle from the PHY core
	typedef struct packed {
		logic link;
		logic tx_act;
		logic rx_act;
		logic col;
		logic speed100;
		logic full_duplex;
		logic act_stretch;
		logic lpi;
		logic mii_err;
		logic blink;
	} phy_status_t;

	// Cable measurement engine report
	typedef struct packed {
		logic done;
		logic fail;
	} cable_result_t;
endpackage

/* File: src/phy_diag_reset_led_regs.sv */
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
module phy_diag_reset_led_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic led_strap_pullup,
	input wire phy_regs_pkg::phy_status_t phy_status,
	input wire phy_regs_pkg::cable_result_t cable_result,
	input wire logic prbs_error,
	input wire logic error_count_cleared,
	input wire logic bmsr_read,
	output logic cable_start,
	output logic [10:0] packet_length,
	output logic soft_reset,
	output logic digital_restart,
	output logic col_pin,
	output logic first_led_pin,
	output logic irq
);
	import phy_regs_pkg::*;

	// ==========================================================
	// Register state
	logic [10:0] pkt_len_r;
	logic start_r;
	logic done_r;
	logic fail_r;
	logic [13:0] rst_rsvd_r;
	logic soft_rst_r;
	logic restart_r;
	logic [15:0] multi_purpose_led_r;
	logic strap_taken_r;
	logic lost_latch_r;
	logic prbs_latch_r;
	logic link_d_r;
	logic [IRQ_BITS-1:0] irq_stat_r;
	logic [IRQ_BITS-1:0] irq_mask_r;
	logic rd_en;
	logic wr_en;
	logic mapped;
	logic [9:0] addr;
	logic [31:0] rdata_nxt;
	logic led_raw;
	logic led_val;
	logic [IRQ_BITS-1:0] irq_events;
	logic [15:0] wdata16;
	logic internal_rst_n;
	logic [15:0] len_merged;
	logic [15:0] rst_merged;
	logic [15:0] multi_purpose_led_merged;
	logic [IRQ_BITS-1:0] irq_read_clr;

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Address decode, shared by read and write paths
	function automatic logic is_mapped(input logic [9:0] a);
		is_mapped = (a == ADDR_PKT_LEN) || (a == ADDR_CABLE) || (a == ADDR_RESET) ||
			(a == ADDR_MULTI_PURPOSE_LED) || (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
	endfunction

	// Write strobe of one register, shared by every writable register process
	function automatic logic wr_hit(input logic go, input logic [9:0] a,
		input logic [9:0] target);
		wr_hit = go && (a == target);
	endfunction

	// ==========================================================
	// APB access decode; zero-wait slave
	assign addr = paddr[9:0];
	assign mapped = is_mapped(addr) && (paddr[31:10] == 22'h0);
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_en = psel && penable && !pwrite && mapped;
	assign wdata16 = pwdata[15:0];

	// Software reset acts on the whole register file like the pin
	assign internal_rst_n = presetn && !soft_rst_r;

	// Ready answers every setup cycle, so the access phase never waits;
	// back-to-back transfers see it again one setup later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	// Error flag for any address outside the map, far pages included
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !mapped;
		end
	end

	// Read data caught in setup; unmapped or far addresses read zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else begin
			prdata <= (psel && !penable && !pwrite && mapped) ? rdata_nxt : 32'h0;
		end
	end

	// Read mux
	always_comb begin
		rdata_nxt = 32'h0;
		case (addr)
			ADDR_PKT_LEN: rdata_nxt[10:0] = pkt_len_r;
			ADDR_CABLE: rdata_nxt[15:0] = {start_r, CABLE_RSVD_VAL, done_r, fail_r};
			ADDR_RESET: rdata_nxt[15:0] = {soft_rst_r, restart_r, rst_rsvd_r};
			ADDR_MULTI_PURPOSE_LED: rdata_nxt[15:0] = multi_purpose_led_r;
			ADDR_IRQ_STATUS: rdata_nxt[IRQ_BITS-1:0] = irq_stat_r;
			ADDR_IRQ_MASK: rdata_nxt[IRQ_BITS-1:0] = irq_mask_r;
			default: rdata_nxt = 32'h0;
		endcase
	end

	// Access phase write enable qualified by pready
	logic wr_go;
	logic rd_go;
	assign wr_go = wr_en && pready;
	assign rd_go = rd_en && pready;

	// Byte-lane merged write words; reserved upper bits are dropped
	// where the register keeps them at zero
	assign len_merged = merge16({5'h0, pkt_len_r}, pwdata, pstrb);
	assign rst_merged = merge16({2'b00, rst_rsvd_r}, pwdata, pstrb);
	assign multi_purpose_led_merged = merge16(multi_purpose_led_r, pwdata, pstrb);

	// ==========================================================
	// Packet length register
	always_ff @(posedge pclk or negedge internal_rst_n) begin
		if (!internal_rst_n) begin
			pkt_len_r <= PKT_LEN_RESET;
		end else if (wr_hit(wr_go, addr, ADDR_PKT_LEN)) begin
			pkt_len_r <= len_merged[10:0];
		end
	end

	// Cable diagnostic start, cleared when done sets
	always_ff @(posedge pclk or negedge internal_rst_n) begin
		if (!internal_rst_n) begin
			start_r <= 1'b0;
		end else if (cable_result.done && !done_r) begin
			start_r <= 1'b0;
		end else if (wr_hit(wr_go, addr, ADDR_CABLE) && pstrb[1]) begin
			start_r <= wdata16[CABLE_START_BIT];
		end
	end

	// Completion and failure flags follow the measurement engine
	always_ff @(posedge pclk or negedge internal_rst_n) begin
		if (!internal_rst_n) begin
			done_r <= 1'b1;
			fail_r <= 1'b0;
		end else if (start_r && !cable_result.done) begin
			done_r <= 1'b0;
			fail_r <= 1'b0;
		end else begin
			done_r <= cable_result.done || done_r;
			fail_r <= cable_result.done ? cable_result.fail : fail_r;
		end
	end

	// Reset control: self-clearing software reset and restart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_rst_r <= 1'b0;
			restart_r <= 1'b0;
			rst_rsvd_r <= 14'h0;
		end else if (soft_rst_r) begin
			soft_rst_r <= 1'b0;
			restart_r <= 1'b0;
			rst_rsvd_r <= 14'h0;
		end else if (wr_hit(wr_go, addr, ADDR_RESET)) begin
			soft_rst_r <= pstrb[1] && wdata16[SOFT_RESET_BIT];
			restart_r <= pstrb[1] && wdata16[RESTART_BIT];
			rst_rsvd_r <= rst_merged[13:0];
		end else begin
			restart_r <= 1'b0;
		end
	end

	// Strap is caught in the first clock after reset release
	always_ff @(posedge pclk or negedge internal_rst_n) begin
		if (!internal_rst_n) begin
			strap_taken_r <= 1'b0;
			multi_purpose_led_r <= 16'h0;
		end else if (!strap_taken_r) begin
			strap_taken_r <= 1'b1;
			multi_purpose_led_r[POL_BIT] <= !led_strap_pullup;
		end else if (wr_hit(wr_go, addr, ADDR_MULTI_PURPOSE_LED)) begin
			multi_purpose_led_r <= multi_purpose_led_merged;
		end
	end

	// ==========================================================
	// LED latches for link lost and test pattern errors
	// Previous link level, for the falling-edge detect
	always_ff @(posedge pclk or negedge internal_rst_n) begin
		if (!internal_rst_n) begin
			link_d_r <= 1'b0;
		end else begin
			link_d_r <= phy_status.link;
		end
	end

	// Link-lost latch; a new loss wins over a status read in the same cycle
	always_ff @(posedge pclk or negedge internal_rst_n) begin
		if (!internal_rst_n) begin
			lost_latch_r <= 1'b0;
		end else if (link_d_r && !phy_status.link) begin
			lost_latch_r <= 1'b1;
		end else if (bmsr_read) begin
			lost_latch_r <= 1'b0;
		end
	end

	// Test pattern latch; held until the error counter is cleared
	always_ff @(posedge pclk or negedge internal_rst_n) begin
		if (!internal_rst_n) begin
			prbs_latch_r <= 1'b0;
		end else if (prbs_error) begin
			prbs_latch_r <= 1'b1;
		end else if (error_count_cleared) begin
			prbs_latch_r <= 1'b0;
		end
	end

	// LED source selection
	always_comb begin
		case (led_src_t'(multi_purpose_led_r[SRC_LSB +: 4]))
			SRC_LINK: led_raw = phy_status.link;
			SRC_ACT: led_raw = phy_status.tx_act || phy_status.rx_act;
			SRC_TX: led_raw = phy_status.tx_act;
			SRC_RX: led_raw = phy_status.rx_act;
			SRC_COL: led_raw = phy_status.col;
			SRC_SPD100: led_raw = phy_status.speed100;
			SRC_SPD10: led_raw = !phy_status.speed100;
			SRC_FDX: led_raw = phy_status.full_duplex;
			SRC_LINK_BLINK: led_raw = phy_status.link && !((phy_status.tx_act ||
				phy_status.rx_act) && phy_status.blink);
			SRC_STRETCH: led_raw = phy_status.act_stretch;
			SRC_LINK100FD: led_raw = phy_status.link && phy_status.speed100 &&
				phy_status.full_duplex;
			SRC_LPI: led_raw = phy_status.lpi;
			SRC_MII_ERR: led_raw = phy_status.mii_err;
			SRC_LINK_LOST: led_raw = lost_latch_r;
			SRC_PRBS_ERR: led_raw = prbs_latch_r;
			default: led_raw = 1'b0;
		endcase
	end

	// Active low when polarity bit is zero
	assign led_val = multi_purpose_led_r[POL_BIT] ? led_raw : !led_raw;

	// Pin routing, registered outputs
	always_ff @(posedge pclk or negedge internal_rst_n) begin
		if (!internal_rst_n) begin
			col_pin <= 1'b0;
			first_led_pin <= 1'b0;
		end else begin
			col_pin <= (multi_purpose_led_r[ROUTE_LSB +: 2] == ROUTE_COL) ? led_val : phy_status.col;
			first_led_pin <= (multi_purpose_led_r[ROUTE_LSB +: 2] == ROUTE_LED0) ? led_val :
				!phy_status.link;
		end
	end

	// ==========================================================
	// Interrupt status; set wins over clear-on-read
	assign irq_events = {link_d_r && !phy_status.link,
		cable_result.done && cable_result.fail && !done_r,
		cable_result.done && !done_r};

	// A status read clears only the bits it returned, so an event that
	// lands between the setup and access edges is kept for the next read
	assign irq_read_clr = (rd_go && (addr == ADDR_IRQ_STATUS)) ? prdata[IRQ_BITS-1:0] : '0;

	// Sticky status, one flop per event
	for (genvar g = 0; g < IRQ_BITS; g++) begin : g_irq_bit
		always_ff @(posedge pclk or negedge internal_rst_n) begin
			if (!internal_rst_n) begin
				irq_stat_r[g] <= 1'b0;
			end else if (irq_events[g]) begin
				irq_stat_r[g] <= 1'b1;
			end else if (irq_read_clr[g]) begin
				irq_stat_r[g] <= 1'b0;
			end
		end
	end

	// Mask register, written from the low byte lane
	always_ff @(posedge pclk or negedge internal_rst_n) begin
		if (!internal_rst_n) begin
			irq_mask_r <= '0;
		end else if (wr_hit(wr_go, addr, ADDR_IRQ_MASK) && pstrb[0]) begin
			irq_mask_r <= pwdata[IRQ_BITS-1:0];
		end
	end

	// Level interrupt while any unmasked status bit stands
	always_ff @(posedge pclk or negedge internal_rst_n) begin
		if (!internal_rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Start level toward the measurement engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cable_start <= 1'b0;
		end else begin
			cable_start <= start_r;
		end
	end

	// Length toward the self-test packet generator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			packet_length <= PKT_LEN_RESET;
		end else begin
			packet_length <= pkt_len_r;
		end
	end

	// Whole-device reset pulse toward the rest of the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= soft_rst_r;
		end
	end

	// Restart pulse toward the digital core; registers keep their values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			digital_restart <= 1'b0;
		end else begin
			digital_restart <= restart_r;
		end
	end
endmodule // phy_diag_reset_led_regs

/* File: sim/regs_assertions.sv */
`timescale 1ns/10ps
// ==========
// Port checks
module regs_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire phy_regs_pkg::cable_result_t cable_result,
	input wire logic cable_start,
	input wire logic [10:0] packet_length,
	input wire logic soft_reset,
	input wire logic digital_restart
);
	import phy_regs_pkg::*;
	logic wr;
	logic [9:0] a;
	logic [10:0] wlen;
	// Completed write with both low byte lanes enabled, and its fields
	assign wr = psel && penable && pready && pwrite && pstrb[1:0] == 2'b11 && paddr[31:10] == 22'h0;
	assign a = paddr[9:0];
	assign wlen = pwdata[10:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_bus_answer: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready timing wrong");
	a_len_write: assert property (
		wr && a == ADDR_PKT_LEN |-> ##2 packet_length == $past(wlen, 2))
		else $error("length not written");
	a_start_set: assert property (
		wr && a == ADDR_CABLE && pwdata[15] && !cable_result.done |-> ##2 cable_start)
		else $error("start not set");
	a_start_clear: assert property (cable_start && cable_result.done |-> ##[1:2] !cable_start)
		else $error("start not cleared");
	a_soft_pulse: assert property (
		wr && a == ADDR_RESET && pwdata[15] |-> ##2 soft_reset ##1 !soft_reset)
		else $error("soft reset pulse wrong");
	a_soft_effect: assert property (
		soft_reset |-> ##[1:2] packet_length == PKT_LEN_RESET)
		else $error("soft reset left length");
	a_restart_pulse: assert property (
		wr && a == ADDR_RESET && pwdata[14] |-> ##2 digital_restart ##1 !digital_restart)
		else $error("restart pulse wrong");
	a_restart_keep: assert property (digital_restart |=> $stable(packet_length) [*3])
		else $error("restart changed length");
	a_refuse_far: assert property (
		psel && !penable && paddr[31:10] != 22'h0 |=> pslverr && prdata == 32'h0)
		else $error("far address not refused");
endmodule // regs_assertions

/* File: sim/tb.sv */
`timescale 1ns/10ps
// ==========
// Bench top
module tb;
	import phy_regs_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic strap = 1'b1, prbs = 1'b0, ecc = 1'b0, bmr = 1'b0, er, pol, rt;
	logic pready, pslverr, cst, srst, drst, colp, ledp, irq;
	logic [3:0] cc, pstrb = 4'hf;
	logic [10:0] plen;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, rv, w;
	phy_status_t st = '0;
	cable_result_t cr = '0;
	int n_mismatch = 0, n_checks = 0, seed = 32'h25b3, m_len, i;
	phy_diag_reset_led_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .led_strap_pullup(strap),
		.phy_status(st), .cable_result(cr), .prbs_error(prbs), .error_count_cleared(ecc),
		.bmsr_read(bmr), .cable_start(cst), .packet_length(plen), .soft_reset(srst),
		.digital_restart(drst), .col_pin(colp), .first_led_pin(ledp), .irq(irq));
	// Clock
	always #2 pclk = ~pclk;
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// One APB transfer; waits for pready
	task automatic apb(input logic wn, input logic [31:0] ad, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wn;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) chk("ready", 1, 0);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d);
	endtask
	task automatic rdc(input string nm, input logic [31:0] ad, input logic [31:0] e);
		apb(1'b0, ad, 32'h0);
		chk(nm, e, rd);
	endtask
	// Model of the selected LED source
	function automatic logic src(input logic [3:0] c);
		case (c)
			4'h0: return st.link;
			4'h1: return st.tx_act | st.rx_act;
			4'h2: return st.tx_act;
			4'h3: return st.rx_act;
			4'h4: return st.col;
			4'h5: return st.speed100;
			4'h6: return !st.speed100;
			4'h7: return st.full_duplex;
			4'h8: return st.link & !((st.tx_act | st.rx_act) & st.blink);
			4'h9: return st.act_stretch;
			4'ha: return st.link & st.speed100 & st.full_duplex;
			4'hb: return st.lpi;
			default: return st.mii_err;
		endcase
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Watchdog
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish;
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		cyc(2);
		rdc("len", ADDR_PKT_LEN, 32'h5ee);
		rdc("cdc", ADDR_CABLE, 32'h102);
		rdc("rst", ADDR_RESET, 32'h0);
		rdc("multi_purpose_led", ADDR_MULTI_PURPOSE_LED, 32'h0);
		chk("col", 1, colp);
		rdc("far", 32'h400, 32'h0);
		chk("err", 1, er);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			rv = $random(seed);
			m_len = rv & 32'h7ff;
			wr(ADDR_PKT_LEN, rv);
			wr(32'h0bc, 32'h0);
			rdc("len", ADDR_PKT_LEN, m_len);
			chk("plen", m_len, plen);
		end
		$display("test length done");
		rdc("irqs", ADDR_IRQ_STATUS, 32'h0);
		wr(ADDR_IRQ_MASK, 32'h7);
		wr(ADDR_CABLE, 32'h8000);
		cyc(2);
		chk("start", 1, cst);
		rdc("cdc", ADDR_CABLE, 32'h8100);
		chk("irq", 0, irq);
		cr <= 2'b11;
		cyc(3);
		chk("start", 0, cst);
		chk("irq", 1, irq);
		rdc("irqs", ADDR_IRQ_STATUS, 32'h3);
		cyc(2);
		chk("irq", 0, irq);
		rdc("cdc", ADDR_CABLE, 32'h103);
		cr <= 2'b00;
		wr(ADDR_IRQ_MASK, 32'h0);
		st.link <= 1'b1;
		cyc(2);
		st.link <= 1'b0;
		cyc(3);
		chk("irq", 0, irq);
		rdc("irqs", ADDR_IRQ_STATUS, 32'h4);
		$display("test cable done");
		wr(ADDR_PKT_LEN, 32'h123);
		wr(ADDR_RESET, 32'h4000);
		cyc(2);
		chk("drst", 1, drst);
		cyc(1);
		chk("drst", 0, drst);
		rdc("len", ADDR_PKT_LEN, 32'h123);
		rdc("rst", ADDR_RESET, 32'h0);
		strap <= 1'b0;
		wr(ADDR_RESET, 32'h8000);
		cyc(2);
		chk("srst", 1, srst);
		cyc(1);
		chk("srst", 0, srst);
		rdc("len", ADDR_PKT_LEN, 32'h5ee);
		rdc("rst", ADDR_RESET, 32'h0);
		rdc("multi_purpose_led", ADDR_MULTI_PURPOSE_LED, 32'h200);
		$display("test reset control done");
		for (i = 0; i < 26; i++) begin
			cc = 4'(i % 13);
			rv = $random(seed);
			st <= rv[9:0];
			pol = rv[12];
			rt = rv[13];
			w = {22'h0, pol, 2'h0, cc, 2'h0, rt};
			wr(ADDR_MULTI_PURPOSE_LED, w);
			cyc(3);
			rdc("multi_purpose_led", ADDR_MULTI_PURPOSE_LED, w);
			chk("led", src(w[6:3]) ^ !pol, rt ? ledp : colp);
		end
		$display("test led source done");
		st.link <= 1'b1;
		wr(ADDR_MULTI_PURPOSE_LED, 32'h269);
		bmr <= 1'b1;
		cyc(1);
		bmr <= 1'b0;
		cyc(3);
		chk("lost", 0, ledp);
		st.link <= 1'b0;
		cyc(2);
		st.link <= 1'b1;
		cyc(4);
		chk("lost", 1, ledp);
		bmr <= 1'b1;
		cyc(1);
		bmr <= 1'b0;
		cyc(3);
		chk("lost", 0, ledp);
		wr(ADDR_MULTI_PURPOSE_LED, 32'h271);
		prbs <= 1'b1;
		cyc(1);
		prbs <= 1'b0;
		cyc(6);
		chk("prbs", 1, ledp);
		ecc <= 1'b1;
		cyc(1);
		ecc <= 1'b0;
		cyc(3);
		chk("prbs", 0, ledp);
		$display("test led latch done");
		tally_and_finish;
	end
endmodule // tb
bind phy_diag_reset_led_regs regs_assertions chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.cable_result(cable_result), .cable_start(cable_start), .packet_length(packet_length),
	.soft_reset(soft_reset), .digital_restart(digital_restart));
